//--- logic/pwm_shutdown_pkg.sv
package pwm_shutdown_pkg;

  // register byte addresses (no offsets printed, so chosen here)
  localparam logic [7:0] addr_auto_shutdown_control = 8'h00;
  localparam logic [7:0] addr_enhanced_pwm_control  = 8'h04;
  localparam logic [7:0] addr_irq_status            = 8'h08;
  localparam logic [7:0] addr_irq_enable            = 8'h0C;
  localparam logic [7:0] addr_irq_clear             = 8'h10;
  localparam logic [7:0] addr_half_bridge_mode      = 8'h14;

  // field positions of auto_shutdown_control
  localparam int pos_event_status = 7;
  localparam int pos_source_hi    = 6;
  localparam int pos_source_lo    = 4;
  localparam int pos_ac_hi        = 3;
  localparam int pos_ac_lo        = 2;
  localparam int pos_bd_hi        = 1;
  localparam int pos_bd_lo        = 0;
  // field positions of enhanced_pwm_control
  localparam int pos_restart_enable = 7;
  localparam int deadband_width     = 7;

  // values after reset
  localparam logic [7:0] reset_auto_shutdown_control = 8'h00;
  localparam logic [7:0] reset_enhanced_pwm_control  = 8'h00;
  localparam logic [1:0] reset_irq                   = 2'h0;

  // interrupt status bits
  localparam int irq_shutdown_entered = 0;
  localparam int irq_restarted        = 1;

  // pair shutdown state codes
  localparam logic [1:0] pair_drive_low  = 2'h0;
  localparam logic [1:0] pair_drive_high = 2'h1;

  // dead-band counts one instruction cycle of four oscillator periods
  localparam int tosc_per_count = 4;

  // axi response codes
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // one output pin as two signals
  typedef struct packed {
    logic level;
    logic enable;
  } pin_drive_t;

  // four pins of the output stage
  typedef struct packed {
    pin_drive_t d;
    pin_drive_t c;
    pin_drive_t b;
    pin_drive_t a;
  } pin_group_t;

  // dead-band stage states
  typedef enum logic [2:0] {
    db_idle  = 3'b001,
    db_delay = 3'b010,
    db_on    = 3'b100
  } db_state_t;

endpackage

//--- logic/deadband_delay.sv
`timescale 1ns/1ps
// delays each rising edge of a level by a programmed count, falling edges pass at once
module deadband_delay
  import pwm_shutdown_pkg::*;
#(
  parameter int count_width = deadband_width
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // control
  input  wire logic [count_width-1:0] delay_count,
  // signal
  input  wire logic                   level_in,
  output logic                        level_out
);

  db_state_t              state;      // stage state
  db_state_t              next_state; // next stage state
  logic [count_width-1:0] elapsed;    // cycles since the rise, entry counts one

  // only inactive-to-active is delayed; a drop cancels the delay at once
  always_comb begin
    next_state = state;
    case (state)
      db_idle: begin
        if (level_in && delay_count <= count_width'(1)) begin
          next_state = db_on; // [R12]
        end else if (level_in) begin
          next_state = db_delay; // [R11]
        end
      end
      db_delay: begin
        if (!level_in) begin
          next_state = db_idle; // [R15]
        end else if (elapsed == delay_count - 1'b1) begin
          next_state = db_on; // [R12]
        end
      end
      db_on: begin
        if (!level_in) begin
          next_state = db_idle; // [R11]
        end
      end
      default: next_state = db_idle;
    endcase
  end

  // state and cycle counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state   <= db_idle;
      elapsed <= '0;
    end else begin
      state   <= next_state;
      elapsed <= (next_state != db_delay) ? '0 :
                 (state == db_delay)      ? elapsed + count_width'(1) : count_width'(1);
    end
  end

  // a zero count passes the rise with no delay; a drop always passes at once
  assign level_out = level_in && (state == db_on || delay_count == '0);

endmodule

//--- logic/pwm_auto_shutdown_deadband.sv
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// R1 - source codes 000-011 pick comparator sources
// R2 - codes 100-111 add low interrupt pin
// R3 - status bit 7 flags shutdown state
// R4 - bits 3-2 set pins a,c shutdown
// R5 - bits 1-0 set pins b,d shutdown
// R6 - shutdown condition is a level
// R7 - status writes ignored while condition present
// R8 - restart waits for next pwm period
// R9 - auto-restart keeps status set while active
// R10 - auto-restart clears status when condition ends
// R11 - dead-band only on inactive-to-active edges
// R12 - dead-band from low seven control bits
// R13 - without auto-restart software clears to restart
// R14 - event sets status, pins forced immediately
// R15 - too-long dead-band keeps output inactive
module pwm_auto_shutdown_deadband
  import pwm_shutdown_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // shutdown sources
  input  wire logic        comparator_one,
  input  wire logic        comparator_two,
  input  wire logic        ext_int_pin,
  // pwm core side
  input  wire logic        pwm_level_a,
  input  wire logic        pwm_level_b,
  input  wire logic        pwm_level_c,
  input  wire logic        pwm_level_d,
  input  wire logic        period_start,
  // output pins
  output logic             pwm_out_a,
  output logic             pwm_out_a_oe,
  output logic             pwm_out_b,
  output logic             pwm_out_b_oe,
  output logic             pwm_out_c,
  output logic             pwm_out_c_oe,
  output logic             pwm_out_d,
  output logic             pwm_out_d_oe,
  // interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [7:0] auto_shutdown_control; // status, source, pair states
  logic [7:0] enhanced_pwm_control;  // restart enable, dead-band
  logic       half_bridge_mode;      // dead-band applies only here
  logic [1:0] irq_status;            // sticky events
  logic [1:0] irq_enable;            // event mask
  logic       resume_wait;           // restarted, waiting for period start

  ////////////////////////////////////////////////////////////////////////////
  // named fields

  // the status bit is state; the other fields are plain storage
  wire       shutdown_event_status = auto_shutdown_control[pos_event_status];
  wire [2:0] shutdown_source_select = auto_shutdown_control[pos_source_hi:pos_source_lo];
  wire [1:0] pair_ac_shutdown_state = auto_shutdown_control[pos_ac_hi:pos_ac_lo];
  wire [1:0] pair_bd_shutdown_state = auto_shutdown_control[pos_bd_hi:pos_bd_lo];
  wire       restart_enable = enhanced_pwm_control[pos_restart_enable];
  wire [deadband_width-1:0] deadband_count = enhanced_pwm_control[deadband_width-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // shutdown condition decode

  // bit 0 and 1 pick comparators, bit 2 adds a low interrupt pin
  wire cond_cmp_one = shutdown_source_select[0] && comparator_one; // [R1]
  wire cond_cmp_two = shutdown_source_select[1] && comparator_two; // [R1]
  wire cond_int_low = shutdown_source_select[2] && !ext_int_pin;   // [R2]
  // code 000 leaves every term low, so no source forces the pins
  // a level, re-evaluated every cycle, never latched by an edge
  wire shutdown_cond = cond_cmp_one || cond_cmp_two || cond_int_low; // [R6]

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  logic       aw_held;   // write address taken
  logic       w_held;    // write data taken
  logic [7:0] aw_addr_q; // captured address
  logic [31:0] w_data_q; // captured data
  logic [3:0] w_strb_q;  // captured strobes

  // a held half blocks its own channel until the response is taken
  assign awready = !aw_held && !bvalid;
  assign wready  = !w_held && !bvalid;

  // decode only once both halves are held; lane 0 carries every register
  wire write_go   = aw_held && w_held && !bvalid;
  wire lane0      = w_strb_q[0];
  wire wr_asc     = write_go && lane0 && aw_addr_q == addr_auto_shutdown_control;
  wire wr_epc     = write_go && lane0 && aw_addr_q == addr_enhanced_pwm_control;
  wire wr_ien     = write_go && lane0 && aw_addr_q == addr_irq_enable;
  wire wr_iclr    = write_go && lane0 && aw_addr_q == addr_irq_clear;
  wire wr_hbm     = write_go && lane0 && aw_addr_q == addr_half_bridge_mode;
  wire wr_mapped  = aw_addr_q == addr_auto_shutdown_control
                 || aw_addr_q == addr_enhanced_pwm_control
                 || aw_addr_q == addr_irq_status
                 || aw_addr_q == addr_irq_enable
                 || aw_addr_q == addr_irq_clear
                 || aw_addr_q == addr_half_bridge_mode;

  // address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (write_go) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held   <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (write_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= resp_okay;
    end else if (write_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_mapped ? resp_okay : resp_slverr;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shutdown status and control registers

  // software may set the status bit, which acts as an event
  wire sw_sets_status   = wr_asc && w_data_q[pos_event_status];
  wire sw_clears_status = wr_asc && !w_data_q[pos_event_status] && !shutdown_cond; // [R7]
  // auto-restart drops the status as soon as the condition is gone
  wire hw_clears_status = restart_enable && !shutdown_cond; // [R10]
  wire status_enters    = (shutdown_cond || sw_sets_status) && !shutdown_event_status;
  wire status_leaves    = shutdown_event_status && !shutdown_cond && !sw_sets_status
                       && (sw_clears_status || hw_clears_status);
  // set always wins over either clear
  wire next_status = shutdown_cond || sw_sets_status                         // [R14] [R9]
                  || (shutdown_event_status && !sw_clears_status && !hw_clears_status); // [R13]

  // status follows next_status every cycle, the other fields only on a write;
  // a plain write never reaches the status bit, so it cannot beat a live condition

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_shutdown_control <= reset_auto_shutdown_control;
    end else begin
      auto_shutdown_control[pos_event_status] <= next_status; // [R3]
      if (wr_asc) begin
        auto_shutdown_control[pos_source_hi:0] <= w_data_q[pos_source_hi:0];
      end
    end
  end

  // enhanced control and half-bridge select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enhanced_pwm_control <= reset_enhanced_pwm_control;
      half_bridge_mode     <= 1'b0;
    end else begin
      if (wr_epc) begin
        enhanced_pwm_control <= w_data_q[7:0];
      end
      if (wr_hbm) begin
        half_bridge_mode <= w_data_q[0];
      end
    end
  end

  // restarted outputs stay quiet until the next period begins
  // a restart mid-period would emit a truncated first pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resume_wait <= 1'b0;
    end else if (next_status) begin
      resume_wait <= 1'b1;
    end else if (period_start) begin
      resume_wait <= 1'b0; // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  // bit 0 marks entry into shutdown, bit 1 the return to normal
  wire [1:0] irq_events = {status_leaves, status_enters};

  // sticky bits; a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= reset_irq;
      irq_enable <= reset_irq;
    end else begin
      irq_status <= irq_events | (irq_status & ~(wr_iclr ? w_data_q[1:0] : 2'h0));
      if (wr_ien) begin
        irq_enable <= w_data_q[1:0];
      end
    end
  end

  // level interrupt, high while any enabled event is pending
  assign irq = |(irq_status & irq_enable);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  wire [7:0] rd_value =
      (araddr == addr_auto_shutdown_control) ? auto_shutdown_control :
      (araddr == addr_enhanced_pwm_control)  ? enhanced_pwm_control :
      (araddr == addr_irq_status)            ? {6'h00, irq_status} :
      (araddr == addr_irq_enable)            ? {6'h00, irq_enable} :
      (araddr == addr_half_bridge_mode)      ? {7'h00, half_bridge_mode} : 8'h00;
  wire rd_mapped = araddr == addr_auto_shutdown_control
                || araddr == addr_enhanced_pwm_control
                || araddr == addr_irq_status
                || araddr == addr_irq_enable
                || araddr == addr_irq_clear
                || araddr == addr_half_bridge_mode;

  // decode uses the live address, which the master holds until arready
  assign arready = !rvalid;

  // data registered one cycle after the address is taken; clear reads zero
  // a read changes no state, so it has no side effects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= resp_okay;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_value};
      rresp  <= rd_mapped ? resp_okay : resp_slverr;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dead-band on the complementary half-bridge pair

  logic db_level_a; // a after dead-band
  logic db_level_b; // b after dead-band

  deadband_delay #(
    .count_width (deadband_width)
  ) u_db_a (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .delay_count (deadband_count), // [R12]
    .level_in    (pwm_level_a),
    .level_out   (db_level_a)
  );

  deadband_delay #(
    .count_width (deadband_width)
  ) u_db_b (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .delay_count (deadband_count), // [R12]
    .level_in    (pwm_level_b),
    .level_out   (db_level_b)
  );

  // pins c and d are not part of the half-bridge pair and pass as they come
  // outside half-bridge mode the levels pass undelayed
  wire run_a = half_bridge_mode ? db_level_a : pwm_level_a; // [R11]
  wire run_b = half_bridge_mode ? db_level_b : pwm_level_b;

  ////////////////////////////////////////////////////////////////////////////
  // output pin forcing

  // forcing is combinational so a live condition reaches the pins at once
  wire forced = shutdown_event_status || shutdown_cond || resume_wait; // [R14] [R6]
  // resume_wait keeps the pins forced until a whole period can start

  wire ac_tri  = pair_ac_shutdown_state[1];                                  // [R4]
  wire ac_lvl  = pair_ac_shutdown_state == pair_drive_high;                  // [R4]
  wire bd_tri  = pair_bd_shutdown_state[1];                                  // [R5]
  wire bd_lvl  = pair_bd_shutdown_state == pair_drive_high;                  // [R5]

  // one shutdown drive per pair; a released pin also drops its level
  pin_drive_t ac_force; // shutdown drive of pins a and c
  pin_drive_t bd_force; // shutdown drive of pins b and d
  assign ac_force = '{level: ac_lvl && !ac_tri, enable: !ac_tri}; // [R4]
  assign bd_force = '{level: bd_lvl && !bd_tri, enable: !bd_tri}; // [R5]

  // both pins of a pair switch together, so a pair never splits
  pin_group_t pins; // assembled pin drives
  assign pins.a = forced ? ac_force : pin_drive_t'{level: run_a, enable: 1'b1};
  assign pins.c = forced ? ac_force : pin_drive_t'{level: pwm_level_c, enable: 1'b1};
  assign pins.b = forced ? bd_force : pin_drive_t'{level: run_b, enable: 1'b1};
  assign pins.d = forced ? bd_force : pin_drive_t'{level: pwm_level_d, enable: 1'b1};

  // unpack onto the pin ports; oe low leaves the pin to its external resistor
  assign pwm_out_a    = pins.a.level;
  assign pwm_out_a_oe = pins.a.enable;
  assign pwm_out_b    = pins.b.level;
  assign pwm_out_b_oe = pins.b.enable;
  assign pwm_out_c    = pins.c.level;
  assign pwm_out_c_oe = pins.c.enable;
  assign pwm_out_d    = pins.d.level;
  assign pwm_out_d_oe = pins.d.enable;

endmodule

//--- verif/pwm_switch_driver_model.sv
`timescale 1ns/1ps
// gate inputs of the external switch drivers, each with a pull-down
module pwm_switch_driver_model
  import pwm_shutdown_pkg::*;
(
  // pins from the output stage
  input  wire pin_group_t pins,
  // level each driver sees
  output logic [3:0]      gate
);
  //////////
  // a released pin sinks to the pull-down, so tri-state never reads as the last level
  assign gate = {pins.d.level & pins.d.enable, pins.c.level & pins.c.enable,
                 pins.b.level & pins.b.enable, pins.a.level & pins.a.enable};
endmodule

//--- verif/pwm_shutdown_checker.sv
`timescale 1ns/1ps
// watches bus handshakes and pin pairing at the block's ports
module pwm_shutdown_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes, grouped to keep the file short
  input wire logic        awvalid, awready, wvalid, wready, bvalid, bready,
  input wire logic        arvalid, arready, rvalid, rready,
  input wire logic [31:0] rdata,
  // pin enables
  input wire logic        pwm_out_a_oe, pwm_out_b_oe, pwm_out_c_oe, pwm_out_d_oe
);
  //////////
  // one domain, so clock and reset are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////
  // write side
  a_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write channels open while a response waits");
  a_write_answer: assert property (awvalid && awready && wvalid && wready
    |=> !bvalid ##1 bvalid)
    else $error("write response not two cycles after the transfer");
  a_b_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write response kept after its handshake");
  // read side
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data not one cycle after the address");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address open while data waits");
  a_r_release: assert property (rvalid && rready |=> !rvalid)
    else $error("read data kept after its handshake");
  a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  // pins of one pair always share one enable
  a_ac_pair: assert property (pwm_out_a_oe == pwm_out_c_oe)
    else $error("pins a and c differ in enable");
  a_bd_pair: assert property (pwm_out_b_oe == pwm_out_d_oe)
    else $error("pins b and d differ in enable");
endmodule

bind pwm_auto_shutdown_deadband pwm_shutdown_checker chk_u (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .arvalid, .arready, .rvalid, .rready, .rdata,
  .pwm_out_a_oe, .pwm_out_b_oe, .pwm_out_c_oe, .pwm_out_d_oe
);

//--- verif/pwm_auto_shutdown_deadband_tb_top.sv
`timescale 1ns/1ps
module pwm_auto_shutdown_deadband_tb_top
  import pwm_shutdown_pkg::*;
();
  //////////
  // bus and clock
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_resp, wr_resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  // sources, core levels, pins
  logic        comparator_one, comparator_two, ext_int_pin, period_start, irq;
  logic [3:0]  lvl, pout, poe, gate;
  pin_group_t  pins;
  int          errors, compares;
  localparam int db_n = 5; // short count keeps the run brief
  //////////
  pwm_auto_shutdown_deadband dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .comparator_one, .comparator_two, .ext_int_pin, .period_start,
    .pwm_level_a(lvl[0]), .pwm_level_b(lvl[1]), .pwm_level_c(lvl[2]), .pwm_level_d(lvl[3]),
    .pwm_out_a(pout[0]), .pwm_out_a_oe(poe[0]), .pwm_out_b(pout[1]), .pwm_out_b_oe(poe[1]),
    .pwm_out_c(pout[2]), .pwm_out_c_oe(poe[2]), .pwm_out_d(pout[3]), .pwm_out_d_oe(poe[3]),
    .irq
  );
  assign pins = {pout[3], poe[3], pout[2], poe[2], pout[1], poe[1], pout[0], poe[0]};
  pwm_switch_driver_model drv (.pins, .gate);
  //////////
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hang();
    errors++;
    complete_run();
  endtask
  // readies are combinational, so the negedge value is what the next edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta = 0, tw = 0, tb = 0, ea, ew;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge aclk);
      ea = !ta && awready === 1'b1;
      ew = !tw && wready === 1'b1;
      tb = ta && tw && bvalid === 1'b1;
      wr_resp = bresp;
      @(posedge aclk);
      if (ea) awvalid <= 1'b0;
      if (ew) wvalid <= 1'b0;
      ta |= ea;
      tw |= ew;
    end
    bready <= 1'b0;
    if (!tb) hang();
  endtask
  task automatic rd(input logic [7:0] a);
    bit ta = 0, tb = 0, ea;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge aclk);
      ea = !ta && arready === 1'b1;
      tb = ta && rvalid === 1'b1;
      rd_val  = rdata;
      rd_resp = rresp;
      @(posedge aclk);
      if (ea) arvalid <= 1'b0;
      ta |= ea;
    end
    rready <= 1'b0;
    if (!tb) hang();
  endtask
  // one period start, then settle
  task automatic pulse_period();
    @(posedge aclk);
    period_start <= 1'b1;
    @(posedge aclk);
    period_start <= 1'b0;
    @(negedge aclk);
  endtask
  //////////
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  //////////
  initial begin
    int c, s, h;
    logic [1:0] ac, bd;
    errors = 0;
    compares = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    {comparator_one, comparator_two, period_start} = '0;
    ext_int_pin = 1'b1;
    lvl = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and an unmapped place
    rd(addr_auto_shutdown_control);
    chk("asc reset", rd_val, 32'(reset_auto_shutdown_control));
    chk("mapped rd resp", rd_resp, resp_okay);
    rd(addr_enhanced_pwm_control);
    chk("epc reset", rd_val, 32'(reset_enhanced_pwm_control));
    rd(8'h18);
    chk("unmapped resp", rd_resp, resp_slverr);
    chk("unmapped data", rd_val, 32'h0000_0000);
    wr(8'h18, 32'h0000_0001);
    chk("unmapped wr resp", wr_resp, resp_slverr);
    // every select code against each single source, pairs driven low
    for (c = 0; c < 8; c++) begin
      for (s = 0; s < 3; s++) begin
        h = c[s];
        wr(addr_auto_shutdown_control, 32'(c * 16));
        comparator_one <= s == 0;
        comparator_two <= s == 1;
        ext_int_pin    <= s != 2;
        @(negedge aclk);
        chk("forced pins", gate, h ? 4'h0 : 4'hf);
        @(posedge aclk);
        {comparator_one, comparator_two, ext_int_pin} <= 3'h1;
        rd(addr_auto_shutdown_control);
        chk("status kept", rd_val, 32'(h * 128 + c * 16));
        wr(addr_auto_shutdown_control, 32'(c * 16));
        @(negedge aclk);
        chk("held pins", gate, h ? 4'h0 : 4'hf);
        pulse_period();
        chk("resumed pins", gate, 4'hf);
      end
    end
    // each pair state, entered by a software event
    for (c = 0; c < 4; c++) begin
      ac = c[1:0];
      bd = ~ac;
      lvl <= {~bd[0], ~ac[0], ~bd[0], ~ac[0]};
      wr(addr_auto_shutdown_control, 32'(128 + c * 4 + 3 - c));
      @(negedge aclk);
      chk("pair level", gate, {bd == 1, ac == 1, bd == 1, ac == 1});
      chk("pair enable", poe, {~bd[1], ~ac[1], ~bd[1], ~ac[1]});
      wr(addr_auto_shutdown_control, 32'h0000_0000);
      pulse_period();
    end
    // auto restart with interrupts raised, cleared, masked
    lvl <= 4'hf;
    wr(addr_irq_clear, 32'h0000_0003);
    chk("clear wr resp", wr_resp, resp_okay);
    wr(addr_irq_enable, 32'h0000_0003);
    @(negedge aclk);
    chk("irq idle", irq, 1'b0);
    wr(addr_enhanced_pwm_control, 32'h0000_0080);
    wr(addr_auto_shutdown_control, 32'h0000_0010);
    comparator_one <= 1'b1;
    wr(addr_auto_shutdown_control, 32'h0000_0010);
    rd(addr_auto_shutdown_control);
    chk("status held", rd_val, 32'h0000_0090);
    @(negedge aclk);
    chk("irq raised", irq, 1'b1);
    @(posedge aclk);
    comparator_one <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(addr_auto_shutdown_control);
    chk("auto cleared", rd_val, 32'h0000_0010);
    pulse_period();
    chk("auto resumed", gate, 4'hf);
    rd(addr_irq_status);
    chk("irq status", rd_val, 32'h0000_0003);
    wr(addr_irq_clear, 32'h0000_0003);
    @(negedge aclk);
    chk("irq cleared", irq, 1'b0);
    wr(addr_irq_enable, 32'h0000_0000);
    comparator_one <= 1'b1;
    repeat (4) @(negedge aclk);
    chk("irq masked", irq, 1'b0);
    @(posedge aclk);
    comparator_one <= 1'b0;
    wr(addr_enhanced_pwm_control, 32'h0000_0000);
    pulse_period();
    // dead-band delays rises only; too short a pulse never shows
    lvl <= 4'h0;
    wr(addr_half_bridge_mode, 32'h0000_0001);
    wr(addr_enhanced_pwm_control, 32'(db_n));
    lvl <= 4'h1;
    for (c = 0; c < db_n; c++) begin
      @(negedge aclk);
      chk("delayed rise", gate[0], 1'b0);
    end
    @(negedge aclk);
    chk("late rise", gate[0], 1'b1);
    @(posedge aclk);
    lvl <= 4'h0;
    @(negedge aclk);
    chk("prompt fall", gate[0], 1'b0);
    for (c = 0; c < 8; c++) begin
      @(posedge aclk);
      lvl <= 4'(c < 2);
      @(negedge aclk);
      chk("short pulse", gate[0], 1'b0);
    end
    complete_run();
  end
endmodule
